// >>> hdl/xtc_pkg.sv
// Package for the crystal trim and oscillator calibration block.
// Assumes a single 50 MHz system clock and a plain register port.
package xtc_pkg;

	// Register offsets (word index on the plain register port)
	localparam logic [3:0] ADDR_TRIM      = 4'h0; // Trim code, active in immediate mode
	localparam logic [3:0] ADDR_STORED    = 4'h1; // Stored trim, counter, current and progressive modes
	localparam logic [3:0] ADDR_STAGE1    = 4'h2; // Progressive stage 1 trim
	localparam logic [3:0] ADDR_STAGE2    = 4'h3; // Progressive stage 2 trim
	localparam logic [3:0] ADDR_TRIMCTL   = 4'h4; // Mode, settle threshold
	localparam logic [3:0] ADDR_COUNT_N   = 4'h5; // Counter mode trim point
	localparam logic [3:0] ADDR_IRQ_THR   = 4'h6; // Settled interrupt threshold
	localparam logic [3:0] ADDR_SHADOW    = 4'h7; // Start-up count shadow (RO)
	localparam logic [3:0] ADDR_STATUS    = 4'h8; // Status (RO)
	localparam logic [3:0] ADDR_REF_CTL   = 4'h9; // Reference select and start
	localparam logic [3:0] ADDR_REF_N     = 4'hA; // Measurement period count
	localparam logic [3:0] ADDR_REF_M     = 4'hB; // Measurement result (RO)
	localparam logic [3:0] ADDR_CTL       = 4'hC; // Start-up sequencer control

	// Field positions
	localparam int TRIMCTL_SEL_LSB   = 0;  // Mode select [1:0]
	localparam int TRIMCTL_SETTLE_LSB = 8; // Settle threshold [15:8]
	localparam int REF_SEL_LSB       = 0;  // Reference select [1:0]
	localparam int REF_START_BIT     = 2;  // Calibration start
	localparam int CTL_WAKE_BIT      = 0;  // 1 = wake from sleep, 0 = power-up
	localparam int CTL_GO_BIT        = 1;  // Write 1 to start sequence
	localparam int ST_SETTLE_BIT     = 0;  // Settle-ready flag
	localparam int ST_IRQ_BIT        = 1;  // Settled flag
	localparam int ST_OSC_BIT        = 2;  // Oscillator enabled

	// Reset values
	localparam logic [10:0] TRIM_RST     = 11'h000;
	localparam logic [7:0]  SETTLE_RST   = 8'h08;
	localparam logic [15:0] COUNT_N_RST  = 16'h0010;
	localparam logic [15:0] IRQ_THR_RST  = 16'h0020;
	localparam logic [31:0] REF_N_RST    = 32'h0000_0001;

	// Divided clock: 16 MHz enable from a 50 MHz clock by phase accumulator
	localparam int SYS_HZ  = 50_000_000;
	localparam int DIVN_HZ = 16_000_000;

	// Trim application modes
	typedef enum logic [1:0] {
		XTC_MODE_COUNTER     = 2'h0,
		XTC_MODE_CURRENT     = 2'h1,
		XTC_MODE_IMMEDIATE   = 2'h2,
		XTC_MODE_PROGRESSIVE = 2'h3
	} xtc_mode_t;

	// Analog oscillator indications
	typedef struct packed {
		logic cap_charged;   // Internal capacitor charged
		logic current_drop;  // Oscillator current dropped
	} xtc_ana_t;

	// Status bundle
	typedef struct packed {
		logic osc_on;
		logic settled;
		logic settle_ready;
	} xtc_stat_t;

endpackage

// >>> hdl/xtc_top.sv
// Crystal trim sequencer and reference-clock frequency measurement.
// Assumes slow clocks and analog indications arrive asynchronously on pins.
`timescale 1ns/100ps

// Summary of operation
// RULE1: One code trims both capacitor banks together
// RULE2: Code zero is max capacitance, lowest frequency
// RULE3: Low eight bits drive binary capacitors directly
// RULE4: Top three bits thermometer decode to seven
// RULE5: Each decoded output switches a 256-unit capacitor
// RULE6: Settled interrupt at programmed start-up count
// RULE7: Counter ticks on slow RC or lp clock
// RULE8: Hardware enables oscillator, start-up then settling
// RULE9: Two-bit select, counter mode by default
// RULE10: Counter mode applies trim at N-1
// RULE11: Current mode applies trim at current drop
// RULE12: Immediate mode follows trim register continuously
// RULE13: Progressive mode applies three trims in stages
// RULE14: Shadow captures count at final trim
// RULE15: Settle flag when crystal count reaches threshold
// RULE16: Software loads N before measuring
// RULE17: Select picks one of four measured clocks
// RULE18: Start bit self-clears when measurement done
// RULE19: Count 16 MHz ticks over N periods
// RULE20: Divided clock always 16 MHz equivalent
// RULE21: Fields return to defaults on reset
module xtc_top #(
	parameter int CNT_W = 16   // Start-up counter width
) (
	// System
	input  wire logic        clk_sys,
	input  wire logic        rst,
	// Register port
	input  wire logic [3:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	// Slow clocks as pins
	input  wire logic        slow_rc_osc,
	input  wire logic        lp_clk_in,
	input  wire logic        fast_rc_osc,
	input  wire logic        slow_crystal_osc,
	input  wire logic        enhanced_slow_rc_osc,
	input  wire logic        fast_crystal_osc,
	// Analog indications
	input  xtc_pkg::xtc_ana_t ana_in,
	// Analog controls
	output logic             osc_enable,
	output logic      [7:0]  cap_binary,
	output logic      [6:0]  cap_thermo,
	// Notification
	output logic             crystal_settled_irq
);

	// Synchroniser stages: first stage read only by the second
	logic [7:0] sync1_r;
	logic [7:0] sync2_r;
	logic [7:0] sync3_r;    // Edge history, fed from the second stage only
	logic [7:0] rise;

	// Registers
	logic [10:0] crystal_capacitor_trim_r;  // Immediate-mode code
	logic [10:0] stored_trim_value_r;
	logic [10:0] stage1_trim_r;
	logic [10:0] stage2_trim_r;
	logic [1:0]  mode_r;
	logic [7:0]  settle_count_threshold_r;
	logic [CNT_W-1:0] count_n_r;
	logic [CNT_W-1:0] settle_irq_threshold_r;
	logic [CNT_W-1:0] startup_count_shadow_r;
	logic        wake_r;
	logic [1:0]  ref_sel_r;
	logic        ref_start_r;
	logic [31:0] measure_period_count_r;
	logic [31:0] measure_result_r;

	// Sequencer
	typedef enum {SQ_IDLE, SQ_STARTUP, SQ_SETTLE, SQ_DONE} xtc_seq_t;
	xtc_seq_t    seq_r;
	logic [CNT_W-1:0] startup_cnt_r;
	logic [10:0] applied_trim_r;
	logic [1:0]  stage_r;                   // Progressive stage reached
	logic        final_trim_switch;
	logic        settled_r;
	logic [7:0]  crystal_cycle_counter_r;
	logic        settle_flag_r;
	logic        go;
	logic        cnt_tick;
	logic [10:0] trim_code;

	// Measurement
	logic [31:0] period_cnt_r;
	logic        divn_tick;
	// Seven bits: a phase below 50 plus 16 reaches 65, so six bits would wrap
	// and the accumulator would cycle 0, 16, 32, 48 without ever ticking
	logic [6:0]  phase_r;                   // Phase accumulator, units of 1 MHz
	logic [6:0]  phase_sum;
	logic        ref_rise;

	// Two flip-flops before any logic reads a pin
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			sync1_r <= 8'h00;
			sync2_r <= 8'h00;
			sync3_r <= 8'h00;
		end else begin
			sync1_r <= {ana_in.cap_charged, ana_in.current_drop, fast_crystal_osc, enhanced_slow_rc_osc,
				slow_crystal_osc, fast_rc_osc, lp_clk_in, slow_rc_osc};
			sync2_r <= sync1_r;
			sync3_r <= sync2_r;
		end
	end
	assign rise = sync2_r & ~sync3_r;

	// Start-up counter clock: slow RC at power-up, lp clock at wake
	assign cnt_tick = wake_r ? rise[1] : rise[0];   // see RULE7
	assign go       = reg_wr && (reg_addr == xtc_pkg::ADDR_CTL) && reg_wdata[xtc_pkg::CTL_GO_BIT];

	// Register writes; defaults on reset
	always_ff @(posedge clk_sys) begin
		if (rst) begin   // see RULE21
			crystal_capacitor_trim_r <= xtc_pkg::TRIM_RST;
			stored_trim_value_r      <= xtc_pkg::TRIM_RST;
			stage1_trim_r            <= xtc_pkg::TRIM_RST;
			stage2_trim_r            <= xtc_pkg::TRIM_RST;
			mode_r                   <= 2'(xtc_pkg::XTC_MODE_COUNTER); // see RULE9
			settle_count_threshold_r <= xtc_pkg::SETTLE_RST;
			count_n_r                <= CNT_W'(xtc_pkg::COUNT_N_RST);
			settle_irq_threshold_r   <= CNT_W'(xtc_pkg::IRQ_THR_RST);
			wake_r                   <= 1'b0;
			ref_sel_r                <= 2'h0;
			measure_period_count_r   <= xtc_pkg::REF_N_RST;
		end else if (reg_wr) begin
			unique case (reg_addr)
				xtc_pkg::ADDR_TRIM:    crystal_capacitor_trim_r <= reg_wdata[10:0];
				xtc_pkg::ADDR_STORED:  stored_trim_value_r      <= reg_wdata[10:0];
				xtc_pkg::ADDR_STAGE1:  stage1_trim_r            <= reg_wdata[10:0];
				xtc_pkg::ADDR_STAGE2:  stage2_trim_r            <= reg_wdata[10:0];
				xtc_pkg::ADDR_TRIMCTL: begin
					mode_r                   <= reg_wdata[xtc_pkg::TRIMCTL_SEL_LSB +: 2];
					settle_count_threshold_r <= reg_wdata[xtc_pkg::TRIMCTL_SETTLE_LSB +: 8];
				end
				xtc_pkg::ADDR_COUNT_N: count_n_r              <= reg_wdata[CNT_W-1:0];
				xtc_pkg::ADDR_IRQ_THR: settle_irq_threshold_r <= reg_wdata[CNT_W-1:0];
				xtc_pkg::ADDR_REF_CTL: begin
					// Selection frozen during a measurement
					if (!ref_start_r) begin
						ref_sel_r <= reg_wdata[xtc_pkg::REF_SEL_LSB +: 2];
					end
				end
				xtc_pkg::ADDR_REF_N:   begin   // see RULE16
					if (!ref_start_r) begin
						measure_period_count_r <= reg_wdata;
					end
				end
				xtc_pkg::ADDR_CTL:     wake_r <= reg_wdata[xtc_pkg::CTL_WAKE_BIT];
				default: ;
			endcase
		end
	end

	// Sequencer: hardware enables oscillator, start-up then settling
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			seq_r          <= SQ_IDLE;
			startup_cnt_r  <= '0;
			stage_r        <= 2'h0;
			applied_trim_r <= xtc_pkg::TRIM_RST;
			settled_r      <= 1'b0;
		end else begin
			unique case (seq_r)
				SQ_IDLE: begin
					if (go) begin   // see RULE8
						seq_r         <= SQ_STARTUP;
						startup_cnt_r <= '0;
						settled_r     <= 1'b0;
						stage_r       <= 2'h0;
						// First progressive trim at oscillator enable
						if (mode_r == 2'(xtc_pkg::XTC_MODE_PROGRESSIVE)) begin
							applied_trim_r <= stage1_trim_r;   // see RULE13
						end
					end
				end
				SQ_STARTUP, SQ_SETTLE: begin
					if (cnt_tick) begin
						startup_cnt_r <= startup_cnt_r + 1'b1;
					end
					if (final_trim_switch) begin
						seq_r <= SQ_SETTLE;   // see RULE8
						if (mode_r == 2'(xtc_pkg::XTC_MODE_PROGRESSIVE)) begin
							applied_trim_r <= stored_trim_value_r;   // see RULE13
						end else begin
							applied_trim_r <= stored_trim_value_r;   // see RULE10
						end
					end else if (seq_r == SQ_STARTUP && mode_r == 2'(xtc_pkg::XTC_MODE_PROGRESSIVE)
						&& stage_r == 2'h0 && sync2_r[7]) begin
						stage_r        <= 2'h1;
						applied_trim_r <= stage2_trim_r;   // see RULE13
					end
					// Interrupt when counter hits the programmed threshold
					if (startup_cnt_r == settle_irq_threshold_r) begin
						settled_r <= 1'b1;   // see RULE6
						seq_r     <= SQ_DONE;
					end
				end
				SQ_DONE: begin
					if (go) begin
						seq_r     <= SQ_IDLE;
						settled_r <= 1'b0;
					end
				end
			endcase
		end
	end

	// Final trim point per mode
	always_comb begin
		final_trim_switch = 1'b0;
		if (seq_r == SQ_STARTUP) begin
			unique case (mode_r)
				2'(xtc_pkg::XTC_MODE_COUNTER):     final_trim_switch = (startup_cnt_r == count_n_r - 1'b1); // see RULE10
				2'(xtc_pkg::XTC_MODE_CURRENT):     final_trim_switch = sync2_r[6];   // see RULE11
				2'(xtc_pkg::XTC_MODE_PROGRESSIVE): final_trim_switch = sync2_r[6] && stage_r == 2'h1;
				2'(xtc_pkg::XTC_MODE_IMMEDIATE):   final_trim_switch = 1'b1;
			endcase
		end
	end

	// Shadow of the start-up count at the final trim, current and progressive modes only
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			startup_count_shadow_r <= '0;
		end else if (final_trim_switch && (mode_r == 2'(xtc_pkg::XTC_MODE_CURRENT)
			|| mode_r == 2'(xtc_pkg::XTC_MODE_PROGRESSIVE))) begin
			startup_count_shadow_r <= startup_cnt_r;   // see RULE14
		end
	end

	// Crystal cycle counter drives the settle flag
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			crystal_cycle_counter_r <= 8'h00;
			settle_flag_r           <= 1'b0;
		end else if (seq_r == SQ_IDLE) begin
			crystal_cycle_counter_r <= 8'h00;
			settle_flag_r           <= 1'b0;
		end else if (seq_r != SQ_STARTUP && rise[5]) begin
			if (crystal_cycle_counter_r != 8'hFF) begin
				crystal_cycle_counter_r <= crystal_cycle_counter_r + 8'h01;
			end
			if (crystal_cycle_counter_r >= settle_count_threshold_r) begin
				settle_flag_r <= 1'b1;   // see RULE15
			end
		end
	end

	// Immediate mode bypasses the sequencer
	assign trim_code = (mode_r == 2'(xtc_pkg::XTC_MODE_IMMEDIATE)) ? crystal_capacitor_trim_r
		: applied_trim_r;   // see RULE12

	// Drive both banks from one code
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			cap_binary <= 8'h00;
			cap_thermo <= 7'h01;
			osc_enable <= 1'b0;
		end else begin
			cap_binary <= trim_code[7:0];   // see RULE1, RULE3
			cap_thermo <= thermo(trim_code[10:8]);   // see RULE2, RULE4, RULE5
			osc_enable <= (seq_r != SQ_IDLE);   // see RULE8
		end
	end

	// Thermometer decode; 000 and 001 both light output 0
	function automatic logic [6:0] thermo(input logic [2:0] code);
		logic [6:0] t;
		t = 7'h01;
		for (int i = 1; i < 7; i++) begin
			if (int'(code) > i) begin
				t[i] = 1'b1;
			end
		end
		if (code == 3'h7) begin
			t = 7'h7F;
		end
		return t;
	endfunction

	assign crystal_settled_irq = settled_r;

	// 16 MHz tick from 50 MHz; 16 ticks per 50 clocks on average
	assign phase_sum = phase_r + 7'(xtc_pkg::DIVN_HZ / 1_000_000);
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			phase_r   <= 7'h00;
			divn_tick <= 1'b0;
		end else if (phase_sum >= 7'(xtc_pkg::SYS_HZ / 1_000_000)) begin
			phase_r   <= phase_sum - 7'(xtc_pkg::SYS_HZ / 1_000_000);
			divn_tick <= 1'b1;   // see RULE20
		end else begin
			phase_r   <= phase_sum;
			divn_tick <= 1'b0;
		end
	end

	// Measured clock selection
	always_comb begin
		unique case (ref_sel_r)   // see RULE17
			2'h0: ref_rise = rise[0];
			2'h1: ref_rise = rise[2];
			2'h2: ref_rise = rise[3];
			2'h3: ref_rise = rise[4];
		endcase
	end

	// Measurement: M divided ticks over N reference periods
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ref_start_r      <= 1'b0;
			period_cnt_r     <= 32'h0000_0000;
			measure_result_r <= 32'h0000_0000;
		end else if (!ref_start_r) begin
			if (reg_wr && reg_addr == xtc_pkg::ADDR_REF_CTL && reg_wdata[xtc_pkg::REF_START_BIT]) begin
				ref_start_r      <= 1'b1;   // see RULE18
				period_cnt_r     <= 32'h0000_0000;
				measure_result_r <= 32'h0000_0000;
			end
		end else begin
			if (divn_tick && period_cnt_r != 32'h0000_0000) begin
				measure_result_r <= measure_result_r + 32'h0000_0001;   // see RULE19
			end
			if (ref_rise) begin
				// First edge opens the window, N more close it
				if (period_cnt_r == measure_period_count_r) begin
					ref_start_r <= 1'b0;   // see RULE18
				end else begin
					period_cnt_r <= period_cnt_r + 32'h0000_0001;
				end
			end
		end
	end

	// Read data one cycle after the strobe
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			reg_rdata <= 32'h0000_0000;
		end else if (reg_rd) begin
			unique case (reg_addr)
				xtc_pkg::ADDR_TRIM:    reg_rdata <= {21'h0, crystal_capacitor_trim_r};
				xtc_pkg::ADDR_STORED:  reg_rdata <= {21'h0, stored_trim_value_r};
				xtc_pkg::ADDR_STAGE1:  reg_rdata <= {21'h0, stage1_trim_r};
				xtc_pkg::ADDR_STAGE2:  reg_rdata <= {21'h0, stage2_trim_r};
				xtc_pkg::ADDR_TRIMCTL: reg_rdata <= {16'h0, settle_count_threshold_r, 6'h0, mode_r};
				xtc_pkg::ADDR_COUNT_N: reg_rdata <= 32'(count_n_r);
				xtc_pkg::ADDR_IRQ_THR: reg_rdata <= 32'(settle_irq_threshold_r);
				xtc_pkg::ADDR_SHADOW:  reg_rdata <= 32'(startup_count_shadow_r);
				xtc_pkg::ADDR_STATUS:  reg_rdata <= {29'h0, osc_enable, settled_r, settle_flag_r};
				xtc_pkg::ADDR_REF_CTL: reg_rdata <= {29'h0, ref_start_r, ref_sel_r};
				xtc_pkg::ADDR_REF_N:   reg_rdata <= measure_period_count_r;
				xtc_pkg::ADDR_REF_M:   reg_rdata <= measure_result_r;
				xtc_pkg::ADDR_CTL:     reg_rdata <= {31'h0, wake_r};
				default:               reg_rdata <= 32'h0000_0000;
			endcase
		end else begin
			reg_rdata <= 32'h0000_0000;
		end
	end

endmodule

// >>> sim/xtc_osc_model.sv
// Far-side model: free-running oscillators and analog start-up indications.
// Assumes osc_enable from the block; periods are in ns at a 1ns timescale.
`timescale 1ns/100ps
module xtc_osc_model #(
	parameter int T_CAP  = 1500, // Enable to capacitor charged
	parameter int T_DROP = 4000  // Enable to current drop
) (
	// Control from the block
	input  wire logic        osc_enable,
	// Oscillator outputs, running free
	output logic             slow_rc_osc = 1'b0,
	output logic             lp_clk_in = 1'b0,
	output logic             fast_rc_osc = 1'b0,
	output logic             slow_crystal_osc = 1'b0,
	output logic             enhanced_slow_rc_osc = 1'b0,
	output logic             fast_crystal_osc = 1'b0,
	// Analog indications
	output xtc_pkg::xtc_ana_t ana_in = '0
);
	// Four selectable measured clocks plus low-power and crystal clocks
	always #200 slow_rc_osc = ~slow_rc_osc;
	always #260 lp_clk_in = ~lp_clk_in;
	always #90 fast_rc_osc = ~fast_rc_osc;
	always #230 slow_crystal_osc = ~slow_crystal_osc;
	always #350 enhanced_slow_rc_osc = ~enhanced_slow_rc_osc;
	always #31 fast_crystal_osc = ~fast_crystal_osc;
	// Indications follow enable; a late drop is skipped if enable fell
	always begin
		@(posedge osc_enable);
		#(T_CAP) ana_in.cap_charged = osc_enable;
		#(T_DROP - T_CAP) ana_in.current_drop = osc_enable;
	end
	// Oscillator off clears both indications
	always @(negedge osc_enable) ana_in = '0;
endmodule

// >>> sim/xtc_top_assertions.sv
// Checker on the ports of the trim and calibration block.
// Assumes one clock domain and the sync reset on rst.
`timescale 1ns/100ps
module xtc_top_check #(
	parameter int CNT_W = 16 // Mirrors the top module
) (
	input wire logic        clk_sys,
	input wire logic        rst,
	input wire logic [3:0]  reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic        osc_enable,
	input wire logic [7:0]  cap_binary,
	input wire logic [6:0]  cap_thermo,
	input wire logic        crystal_settled_irq
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	logic        imm_r;  // Immediate mode written
	logic [10:0] trim_r; // Shadow of the trim register
	logic [1:0]  age_r;  // Cycles since trim or mode change
	logic        go_wr;  // Sequencer go write
	assign go_wr = reg_wr && reg_addr == xtc_pkg::ADDR_CTL && reg_wdata[xtc_pkg::CTL_GO_BIT];
	// Track the immediate-mode state seen at the bus
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			imm_r <= 1'b0;
			trim_r <= 11'h000;
			age_r <= 2'h0;
		end else begin
			if (reg_wr && reg_addr == xtc_pkg::ADDR_TRIMCTL)
				imm_r <= reg_wdata[1:0] == 2'h2;
			if (reg_wr && reg_addr == xtc_pkg::ADDR_TRIM)
				trim_r <= reg_wdata[10:0];
			age_r <= (reg_wr && reg_addr < 4'h5) ? 2'h0 : ((age_r == 2'h3) ? 2'h3 : age_r + 2'h1);
		end
	end
	// Expected thermometer code
	function automatic logic [6:0] therm(logic [2:0] u);
		return (u < 3'h2) ? 7'h01 : 7'((8'h01 << u) - 8'h01);
	endfunction
	property p_therm; cap_thermo[0] && ((cap_thermo + 7'h01) & cap_thermo) == 7'h00; endproperty
	a_therm: assert property (p_therm) else $error("thermometer code broken");
	property p_imm; imm_r && age_r == 2'h3 |-> {cap_thermo, cap_binary} == {therm(trim_r[10:8]), trim_r[7:0]}; endproperty
	a_imm: assert property (p_imm) else $error("immediate trim not followed");
	property p_rst; $fell(rst) |-> !osc_enable && !crystal_settled_irq && cap_binary == 8'h00 && cap_thermo == 7'h01; endproperty
	a_rst: assert property (p_rst) else $error("reset outputs wrong");
	property p_rdz; !$past(reg_rd) |-> reg_rdata == 32'h0; endproperty
	a_rdz: assert property (p_rdz) else $error("read data outside answer cycle");
	property p_unmap; reg_rd && reg_addr > 4'hC |=> reg_rdata == 32'h0; endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
	property p_go; go_wr && !osc_enable && !crystal_settled_irq |-> ##2 osc_enable; endproperty
	a_go: assert property (p_go) else $error("oscillator not enabled by go");
	property p_irq_osc; $rose(crystal_settled_irq) |-> osc_enable; endproperty
	a_irq_osc: assert property (p_irq_osc) else $error("settled without oscillator");
	property p_hold; crystal_settled_irq && !go_wr && !$past(go_wr) && !$past(go_wr, 2) |=> crystal_settled_irq; endproperty
	a_hold: assert property (p_hold) else $error("settled flag dropped");
	property p_clr; go_wr && crystal_settled_irq |-> ##[1:3] !crystal_settled_irq; endproperty
	a_clr: assert property (p_clr) else $error("settled flag not cleared");
	c_irq: cover property ($rose(crystal_settled_irq));
	c_imm: cover property (imm_r && age_r == 2'h3);
	c_clr: cover property (go_wr && crystal_settled_irq);
	c_unmap: cover property (reg_rd && reg_addr > 4'hC);
endmodule
bind xtc_top xtc_top_check #(.CNT_W(CNT_W)) xtc_top_check_inst (.clk_sys, .rst, .reg_addr, .reg_wdata, .reg_wr,
	.reg_rd, .reg_rdata, .osc_enable, .cap_binary, .cap_thermo, .crystal_settled_irq);

// >>> sim/xtc_top_test.sv
// Self-checking bench for the trim sequencer and reference counter.
// Assumes the oscillator model on the far side and a 50 MHz clock.
`timescale 1ns/100ps
module xtc_top_test;
	logic              clk_sys = 1'b0;
	logic              rst = 1'b1;
	logic [3:0]        reg_addr = 4'h0;
	logic [31:0]       reg_wdata = 32'h0;
	logic              reg_wr = 1'b0;
	logic              reg_rd = 1'b0;
	logic [31:0]       reg_rdata;
	logic              s_rc, s_lp, f_rc, s_xt, e_rc, f_xt; // Oscillator pins
	xtc_pkg::xtc_ana_t ana_in;
	logic              osc_enable, crystal_settled_irq;
	logic [7:0]        cap_binary;
	logic [6:0]        cap_thermo;
	int                num_errors = 0, checks = 0, cnt_rc = 0, cnt_lp = 0;
	int                per [4] = '{400, 180, 460, 700}; // Measured clock periods in ns
	always #10 clk_sys = ~clk_sys;
	// Reference edge counts for the start-up counter
	always @(posedge s_rc) cnt_rc++;
	always @(posedge s_lp) cnt_lp++;
	xtc_top xtc_top_inst (.clk_sys, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .slow_rc_osc(s_rc),
		.lp_clk_in(s_lp), .fast_rc_osc(f_rc), .slow_crystal_osc(s_xt), .enhanced_slow_rc_osc(e_rc),
		.fast_crystal_osc(f_xt), .ana_in, .osc_enable, .cap_binary, .cap_thermo, .crystal_settled_irq);
	xtc_osc_model xtc_osc_model_inst (.osc_enable, .slow_rc_osc(s_rc), .lp_clk_in(s_lp), .fast_rc_osc(f_rc),
		.slow_crystal_osc(s_xt), .enhanced_slow_rc_osc(e_rc), .fast_crystal_osc(f_xt), .ana_in);
	task automatic wr(logic [3:0] a, logic [31:0] d);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	// Read data is taken only in the cycle after the strobe
	task automatic rd(logic [3:0] a, output logic [31:0] d);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	task automatic cmp(string n, logic [31:0] e, logic [31:0] g);
		checks++;
		if (g !== e) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	// Counts that cross a synchroniser may land one step either way
	task automatic near(string n, int e, logic [31:0] g, int t);
		checks++;
		if ($isunknown(g) || int'(g) < e - t || int'(g) > e + t) begin
			num_errors++;
			$display("[FAIL] %s expected %0d seen %0d", n, e, g);
		end
	endtask
	function automatic logic [14:0] caps_of(logic [10:0] t);
		int k;
		k = (t[10:8] < 3'h1) ? 1 : int'(t[10:8]);
		return {7'((1 << k) - 1), t[7:0]};
	endfunction
	task automatic complete_run;
		if (num_errors == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		#400000;
		num_errors++;
		complete_run();
	end
	initial begin
		logic [31:0] d, rv [16];
		logic [10:0] t, fin;
		int i, r, md, wk, e, base, app, drp, capi;
		rv = '{default: 32'h0};
		rv[4] = 32'(xtc_pkg::SETTLE_RST) << 8;
		rv[5] = 32'(xtc_pkg::COUNT_N_RST);
		rv[6] = 32'(xtc_pkg::IRQ_THR_RST);
		rv[10] = xtc_pkg::REF_N_RST;
		void'($urandom(32'h5FCF));
		repeat (3) @(posedge clk_sys);
		rst <= 1'b0;
		// Reset values, read-only writes and unmapped reads
		wr(xtc_pkg::ADDR_STATUS, 32'hFF);
		wr(xtc_pkg::ADDR_REF_M, 32'hFF);
		for (i = 0; i < 16; i++) if (i != 7 && i != 12) begin
			rd(4'(i), d);
			cmp("register default", rv[i], d);
		end
		cmp("reset caps", 32'(caps_of(11'h000)), 32'({cap_thermo, cap_binary}));
		// Immediate mode across every decoder input and both ends
		wr(xtc_pkg::ADDR_TRIMCTL, 32'h2);
		for (i = 0; i < 12; i++) begin
			t = (i < 8) ? 11'(i * 256 + $urandom % 256) : 11'($urandom);
			if (i > 9) t = (i == 10) ? 11'h000 : 11'h7FF;
			wr(xtc_pkg::ADDR_TRIM, 32'(t));
			repeat (3) @(posedge clk_sys);
			#1 cmp("immediate caps", 32'(caps_of(t)), 32'({cap_thermo, cap_binary}));
		end
		rd(xtc_pkg::ADDR_TRIM, d);
		cmp("trim readback", 32'h7FF, d);
		// Sequencer runs: counter, current, progressive on wake clock, counter on wake clock
		for (r = 0; r < 4; r++) begin
			md = (r == 2) ? 3 : (r == 1);
			wk = r >= 2;
			fin = 11'(r * 256) | 11'($urandom % 128 + r % 2 * 128); // Bit 7 differs run to run
			wr(xtc_pkg::ADDR_STORED, 32'(fin));
			wr(xtc_pkg::ADDR_STAGE1, 32'(fin ^ 11'h400));
			wr(xtc_pkg::ADDR_STAGE2, 32'(fin ^ 11'h600));
			wr(xtc_pkg::ADDR_TRIMCTL, 32'h400 | 32'(md));
			wr(xtc_pkg::ADDR_COUNT_N, 32'h8);
			wr(xtc_pkg::ADDR_IRQ_THR, 32'h18);
			base = wk ? cnt_lp : cnt_rc;
			wr(xtc_pkg::ADDR_CTL, 32'h2 | 32'(wk));
			{app, drp, capi} = {-32'sd1, -32'sd1, -32'sd1};
			for (i = 0; i < 4000 && crystal_settled_irq !== 1'b1; i++) begin
				@(posedge clk_sys);
				#1 e = (wk ? cnt_lp : cnt_rc) - base;
				if (drp < 0 && ana_in.current_drop === 1'b1) drp = e;
				if (capi < 0 && ana_in.cap_charged === 1'b1) capi = i;
				if (app < 0 && {cap_thermo, cap_binary} === caps_of(fin)) app = e;
				if (md == 3 && i == 5)
					cmp("stage one caps", 32'(caps_of(fin ^ 11'h400)), 32'({cap_thermo, cap_binary}));
				if (md == 3 && capi >= 0 && i == capi + 8)
					cmp("stage two caps", 32'(caps_of(fin ^ 11'h600)), 32'({cap_thermo, cap_binary}));
			end
			near("settled count", 24, e, 1);
			near("trim point", (md == 0) ? 7 : drp, app, 1);
			rd(xtc_pkg::ADDR_STATUS, d);
			cmp("status", 32'h7, d);
			if (md != 0) begin
				rd(xtc_pkg::ADDR_SHADOW, d);
				near("shadow count", drp, d, 1);
			end
			wr(xtc_pkg::ADDR_CTL, 32'h2);
			repeat (6) @(posedge clk_sys);
			#1 cmp("back to idle", 32'h0, 32'({crystal_settled_irq, osc_enable}));
			repeat (10) @(posedge clk_sys);
		end
		// Measurement of every selectable clock, with a refused write while busy
		for (r = 0; r < 4; r++) begin
			wr(xtc_pkg::ADDR_REF_N, 32'h3);
			wr(xtc_pkg::ADDR_REF_CTL, 32'h4 | 32'(r));
			rd(xtc_pkg::ADDR_REF_CTL, d);
			cmp("start and select", 32'h4 | 32'(r), d & 32'h7);
			wr(xtc_pkg::ADDR_REF_N, 32'h9);
			for (i = 0; i < 500 && d[2] !== 1'b0; i++) rd(xtc_pkg::ADDR_REF_CTL, d);
			cmp("start cleared", 32'h0, 32'(d[2]));
			rd(xtc_pkg::ADDR_REF_M, d);
			near("measured ticks", (3 * per[r] * 16 + 500) / 1000, d, 2);
			rd(xtc_pkg::ADDR_REF_N, d);
			cmp("period count kept", 32'h3, d);
		end
		complete_run();
	end
endmodule
